/* File: core/mrf_pkg.sv */
// package: field layout, encodings and carriers of the fifth mode register
package mrf_pkg;
  // register width and field positions
  localparam int unsigned MR_W = 22;
  localparam int unsigned B_RSV_HI = 21;
  localparam int unsigned B_SEL_HI = 20;
  localparam int unsigned B_SEL_LO = 18;
  localparam int unsigned B_RSV_MID = 17;
  localparam int unsigned B_RSV_LO = 13;
  localparam int unsigned B_RD_INV = 12;
  localparam int unsigned B_WR_INV = 11;
  localparam int unsigned B_WR_MASK = 10;
  localparam int unsigned B_PERSIST = 9;
  localparam int unsigned B_PARK_HI = 8;
  localparam int unsigned B_PARK_LO = 6;
  localparam int unsigned B_ODT_OFF = 5;
  localparam int unsigned B_PAR_ERR = 4;
  localparam int unsigned B_CRC_ERR = 3;
  localparam int unsigned B_LAT_HI = 2;
  localparam int unsigned B_LAT_LO = 0;
  // reset value carries the select code; every function starts disabled
  localparam logic [21:0] MR_RST = 22'h14_0000;
  // bits a write stores; reserved, select and flag bits excluded
  localparam logic [21:0] MR_KEEP = 22'h00_1fe7;
  localparam logic [2:0] SEL_THIS = 3'h5;
  localparam logic [2:0] SEL_NEVER = 3'h7;
  localparam logic [2:0] LAT_OFF = 3'h0;
  localparam logic [2:0] LAT_MAX = 3'h3;
  localparam logic [2:0] LAT_CLK_OFS = 3'h3;
  // parked termination in ohms per code, 0 = disabled
  localparam logic [7:0] PARK_OHM [0:7] = '{8'h00, 8'h3c, 8'h78, 8'h28,
                                            8'hf0, 8'h30, 8'h50, 8'h22};

  // use of the shared data-mask / inversion / strobe pin
  typedef enum logic [1:0] {PIN_NONE, PIN_TSTROBE, PIN_MASK, PIN_INV} mrf_pin_e;

  // command/address pins as sampled on the command clock
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic a17;
    logic [13:0] a;
    logic par;
  } mrf_ca_s;

  // decoded configuration handed to the device core
  typedef struct packed {
    logic rd_inv;
    logic wr_inv;
    logic wr_mask;
    mrf_pin_e pin_fn;
    logic persist;
    logic [2:0] park_code;
    logic [7:0] park_ohms;
    logic odt_off_pd;
    logic nom_term_on;
    logic par_err;
    logic crc_err;
    logic par_en;
    logic [2:0] par_lat;
  } mrf_cfg_s;
endpackage : mrf_pkg

/* File: core/mrf_mode_reg.sv */
// module: fifth mode register, command-clock loading and core-side decode
//
// Function
// - register loads only on mode-set; bank group, bank, A17, A13..A0 map to bits.
// - select bits 20..18 = 101 target here; 111 unused; bits 21,17,13 zero.
// - bit 12 read inversion, bit 11 write inversion, bit 10 write mask.
// - inversion and masking exist only on x8 and x16, never x4.
// - inversion, masking and termination strobe share one pin, one use at a time; read inversion still stays on beside the mask.
// - inversion covers reads and writes; masking covers writes only.
// - during multipurpose readout, read inversion is ignored.
// - bit 9 persistent parity; when 0, checking stops while error flag set.
// - bits 8..6 select parked termination value, 000 disabled.
// - bit 5 turns ODT buffer off in power-down; then no nominal termination.
// - bit 4 parity error flag, set by device, cleared by mode-set write.
// - bit 3 CRC error flag, set by device, cleared by mode-set write.
// - bits 2..0 parity latency 4/5/6 clocks; 000 off; 100 up reserved.
// - with parity on, a command executes only after its check passes.
// - parity covers ACT_n, RAS_n, CAS_n, WE_n, address, bank, group.
`timescale 1ns/1ps
module mrf_mode_reg #(
  parameter int ORG_WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ck,
  input wire mrf_pkg::mrf_ca_s i_ca,
  input wire logic i_crc_err,
  input wire logic i_mpr_read,
  input wire logic i_power_down,
  input wire logic i_termination_strobe_function_en,
  output logic o_cmd_exec,
  output mrf_pkg::mrf_ca_s o_cmd,
  output logic [21:0] o_mode_reg,
  output mrf_pkg::mrf_cfg_s o_cfg
);

  ////////////////////////////////////////////////////////////////////////
  // state of the command-clock side
  typedef struct packed {
    logic rst_m;
    logic rst;
    mrf_pkg::mrf_ca_s ca;
    mrf_pkg::mrf_ca_s cmd;
    logic exec;
    logic [21:0] mr;
    logic [21:0] shadow;
    logic req;
    logic ack_m;
    logic ack_s;
    logic crc_m;
    logic crc_s;
    logic crc_d;
  } mrf_lnk_s;

  // state of the core-clock side
  typedef struct packed {
    logic req_m;
    logic req_s;
    logic ack;
    logic crc_tgl;
    logic [21:0] raw;
    mrf_pkg::mrf_cfg_s cfg;
  } mrf_core_s;

  mrf_lnk_s l_ff;
  mrf_lnk_s nxt_l;
  mrf_core_s c_ff;
  mrf_core_s nxt_c;
  logic is_cmd;
  logic is_mrs;
  logic par_ok;
  logic par_chk;
  logic par_bad;
  logic crc_ev;
  logic wr;
  logic [2:0] sel;
  logic [21:0] wdata;

  ////////////////////////////////////////////////////////////////////////
  // command clock: decode, parity check, register update
  always_comb
  begin
    nxt_l = l_ff;
    // reset arrives from the core domain, two flops before use
    nxt_l.rst_m = i_srst;
    nxt_l.rst = l_ff.rst_m;
    nxt_l.ca = i_ca;
    nxt_l.cmd = l_ff.ca;
    nxt_l.ack_m = c_ff.ack;
    nxt_l.ack_s = l_ff.ack_m;
    nxt_l.crc_m = c_ff.crc_tgl;
    nxt_l.crc_s = l_ff.crc_m;
    nxt_l.crc_d = l_ff.crc_s;
    crc_ev = l_ff.crc_s ^ l_ff.crc_d;
    is_cmd = !l_ff.ca.cs_n;
    // mode-set needs all three strobes low
    is_mrs = is_cmd && l_ff.ca.act_n && !l_ff.ca.ras_n && !l_ff.ca.cas_n && !l_ff.ca.we_n;
    // covered set; CKE, ODT, CS_n stay out
    par_ok = ~^{l_ff.ca.act_n, l_ff.ca.ras_n, l_ff.ca.cas_n, l_ff.ca.we_n,
                l_ff.ca.bg, l_ff.ca.ba, l_ff.ca.a17, l_ff.ca.a, l_ff.ca.par};
    // held error stops checking unless persistent
    par_chk = (l_ff.mr[mrf_pkg::B_LAT_HI:mrf_pkg::B_LAT_LO] != mrf_pkg::LAT_OFF)
              && (l_ff.mr[mrf_pkg::B_LAT_HI:mrf_pkg::B_LAT_LO] <= mrf_pkg::LAT_MAX)
              && (!l_ff.mr[mrf_pkg::B_PAR_ERR] || l_ff.mr[mrf_pkg::B_PERSIST]);
    par_bad = is_cmd && par_chk && !par_ok;
    // pin to bit mapping, bits 16..14 unmapped
    wdata = {l_ff.ca.bg[1], l_ff.ca.bg[0], l_ff.ca.ba[1], l_ff.ca.ba[0],
             l_ff.ca.a17, 3'h0, l_ff.ca.a};
    sel = wdata[mrf_pkg::B_SEL_HI:mrf_pkg::B_SEL_LO];
    // only code 101 lands here; 111 and others leave it alone
    wr = is_mrs && !par_bad && (sel == mrf_pkg::SEL_THIS);
    // execute only a command whose check passed
    nxt_l.exec = is_cmd && !par_bad;
    if (wr)
    begin
      // reserved bits always stored as zero
      nxt_l.mr = (wdata & mrf_pkg::MR_KEEP) | mrf_pkg::MR_RST;
    end
    // sticky, set wins over the clearing write
    nxt_l.mr[mrf_pkg::B_PAR_ERR] = par_bad || (l_ff.mr[mrf_pkg::B_PAR_ERR]
                                   && !(wr && !wdata[mrf_pkg::B_PAR_ERR]));
    // sticky, set wins over the clearing write
    nxt_l.mr[mrf_pkg::B_CRC_ERR] = crc_ev || (l_ff.mr[mrf_pkg::B_CRC_ERR]
                                   && !(wr && !wdata[mrf_pkg::B_CRC_ERR]));
    // snapshot handshake; shadow holds still until the core acks
    if ((l_ff.req == l_ff.ack_s) && (l_ff.shadow != l_ff.mr))
    begin
      nxt_l.shadow = l_ff.mr;
      nxt_l.req = !l_ff.req;
    end
    if (l_ff.rst)
    begin
      nxt_l = '0;
      nxt_l.rst_m = i_srst;
      nxt_l.rst = l_ff.rst_m;
      nxt_l.ca.cs_n = 1'b1;
      nxt_l.cmd.cs_n = 1'b1;
      nxt_l.mr = mrf_pkg::MR_RST;
      nxt_l.shadow = mrf_pkg::MR_RST;
    end
  end

  // command clock register
  always_ff @(posedge i_ck)
  begin
    l_ff <= nxt_l;
  end

  ////////////////////////////////////////////////////////////////////////
  // core clock: take snapshots, forward CRC events, decode fields
  always_comb
  begin
    nxt_c = c_ff;
    nxt_c.req_m = l_ff.req;
    nxt_c.req_s = c_ff.req_m;
    if (c_ff.req_s != c_ff.ack)
    begin
      nxt_c.raw = l_ff.shadow;
      nxt_c.ack = c_ff.req_s;
    end
    // toggle per event; events closer than the crossing merge
    if (i_crc_err)
    begin
      nxt_c.crc_tgl = !c_ff.crc_tgl;
    end
    // x4 parts never invert or mask
    // multipurpose readout forces plain read data
    nxt_c.cfg.rd_inv = c_ff.raw[mrf_pkg::B_RD_INV] && (ORG_WIDTH != 4) && !i_mpr_read;
    // on a forbidden pair the mask keeps the pin
    nxt_c.cfg.wr_inv = c_ff.raw[mrf_pkg::B_WR_INV] && !c_ff.raw[mrf_pkg::B_WR_MASK]
                       && (ORG_WIDTH != 4);
    nxt_c.cfg.wr_mask = c_ff.raw[mrf_pkg::B_WR_MASK] && (ORG_WIDTH != 4);
    // one use of the shared pin, strobe first
    if (i_termination_strobe_function_en && (ORG_WIDTH == 8))
    begin
      nxt_c.cfg.pin_fn = mrf_pkg::PIN_TSTROBE;
      nxt_c.cfg.rd_inv = 1'b0;
      nxt_c.cfg.wr_inv = 1'b0;
      nxt_c.cfg.wr_mask = 1'b0;
    end
    else if (nxt_c.cfg.wr_mask)
    begin
      nxt_c.cfg.pin_fn = mrf_pkg::PIN_MASK;
    end
    else if (nxt_c.cfg.rd_inv || nxt_c.cfg.wr_inv)
    begin
      nxt_c.cfg.pin_fn = mrf_pkg::PIN_INV;
    end
    else
    begin
      nxt_c.cfg.pin_fn = mrf_pkg::PIN_NONE;
    end
    nxt_c.cfg.persist = c_ff.raw[mrf_pkg::B_PERSIST];
    // parked termination code and its value
    nxt_c.cfg.park_code = c_ff.raw[mrf_pkg::B_PARK_HI:mrf_pkg::B_PARK_LO];
    nxt_c.cfg.park_ohms = mrf_pkg::PARK_OHM[c_ff.raw[mrf_pkg::B_PARK_HI:mrf_pkg::B_PARK_LO]];
    // buffer off in power-down drops nominal termination only
    nxt_c.cfg.odt_off_pd = c_ff.raw[mrf_pkg::B_ODT_OFF];
    nxt_c.cfg.nom_term_on = !(i_power_down && c_ff.raw[mrf_pkg::B_ODT_OFF]);
    nxt_c.cfg.par_err = c_ff.raw[mrf_pkg::B_PAR_ERR];
    nxt_c.cfg.crc_err = c_ff.raw[mrf_pkg::B_CRC_ERR];
    // codes 1..3 give 4..6 clocks, reserved codes disable
    nxt_c.cfg.par_en = (c_ff.raw[mrf_pkg::B_LAT_HI:mrf_pkg::B_LAT_LO] != mrf_pkg::LAT_OFF)
                       && (c_ff.raw[mrf_pkg::B_LAT_HI:mrf_pkg::B_LAT_LO] <= mrf_pkg::LAT_MAX);
    nxt_c.cfg.par_lat = nxt_c.cfg.par_en
                        ? c_ff.raw[mrf_pkg::B_LAT_HI:mrf_pkg::B_LAT_LO] + mrf_pkg::LAT_CLK_OFS
                        : 3'h0;
    if (i_srst)
    begin
      nxt_c = '0;
      nxt_c.raw = mrf_pkg::MR_RST;
      nxt_c.cfg.nom_term_on = 1'b1;
    end
  end

  // core clock register
  always_ff @(posedge i_clk)
  begin
    c_ff <= nxt_c;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign o_cmd_exec = l_ff.exec;
  assign o_cmd = l_ff.cmd;
  assign o_mode_reg = l_ff.mr;
  assign o_cfg = c_ff.cfg;

  ////////////////////////////////////////////////////////////////////////
  // checks on the command clock
  a_mrs_loads_fields: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    wr |=> ((l_ff.mr & mrf_pkg::MR_KEEP) == ($past(wdata) & mrf_pkg::MR_KEEP)))
    else $error("mode-set write did not load the register fields");

  a_never_code_ignored: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    (is_mrs && (sel != mrf_pkg::SEL_THIS)) |=> $stable(l_ff.mr & mrf_pkg::MR_KEEP))
    else $error("foreign select code changed the register");

  a_reserved_stay_zero: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    !l_ff.mr[mrf_pkg::B_RSV_HI] && !l_ff.mr[mrf_pkg::B_RSV_MID] && !l_ff.mr[mrf_pkg::B_RSV_LO])
    else $error("reserved bit read back as one");

  a_par_flag_set: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    par_bad |=> l_ff.mr[mrf_pkg::B_PAR_ERR] && !l_ff.exec)
    else $error("parity failure did not set the flag or was executed");

  a_par_flag_sticky: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    (l_ff.mr[mrf_pkg::B_PAR_ERR] && !wr) |=> l_ff.mr[mrf_pkg::B_PAR_ERR])
    else $error("parity flag dropped without a clearing write");

  a_crc_flag_set: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    $rose(l_ff.crc_s) |=> ##1 l_ff.mr[mrf_pkg::B_CRC_ERR])
    else $error("crc event did not set the flag");

  a_held_flag_no_check: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    (is_cmd && l_ff.mr[mrf_pkg::B_PAR_ERR] && !l_ff.mr[mrf_pkg::B_PERSIST]) |=> l_ff.exec)
    else $error("command dropped while checking should be paused");

  a_persist_keeps_check: assert property (
    @(posedge i_ck) disable iff (l_ff.rst)
    (is_cmd && !par_ok && l_ff.mr[mrf_pkg::B_PERSIST] && (l_ff.mr[2:0] == 3'h1)) |=> !l_ff.exec)
    else $error("bad parity executed in persistent mode");

  // checks on the core clock
  a_x4_no_inversion: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (ORG_WIDTH == 4) |-> !(c_ff.cfg.rd_inv || c_ff.cfg.wr_inv || c_ff.cfg.wr_mask))
    else $error("x4 part shows inversion or mask");

  a_readout_no_inv: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_mpr_read |=> !c_ff.cfg.rd_inv)
    else $error("read inversion active during readout");

  a_latency_decode: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (c_ff.raw[2:0] == 3'h2) |=> (c_ff.cfg.par_lat == 3'h5) && c_ff.cfg.par_en)
    else $error("parity latency decoded wrongly");

  a_nom_term_off: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_power_down && c_ff.raw[mrf_pkg::B_ODT_OFF]) |=> !c_ff.cfg.nom_term_on)
    else $error("nominal termination kept with buffer off");

  c_write_here: cover property (@(posedge i_ck) disable iff (l_ff.rst) wr);
  c_parity_drop: cover property (@(posedge i_ck) disable iff (l_ff.rst) par_bad);
  c_crc_seen: cover property (@(posedge i_ck) disable iff (l_ff.rst) crc_ev);
  c_cfg_taken: cover property (@(posedge i_clk) disable iff (i_srst) c_ff.req_s != c_ff.ack);

endmodule : mrf_mode_reg

/* File: sim/mrf_ctrl_model.sv */
// partner model: controller side of the command/address pins
`timescale 1ns/1ps
module mrf_ctrl_model (
  input wire logic i_ck,
  output mrf_pkg::mrf_ca_s o_ca
);
  ////////////////////////////////////////////////////////////////////////
  // pins start deselected
  // lines always driven; no floating input here
  initial o_ca = '1;

  // one command for one clock, then deselect with inverted lines
  task automatic send(input logic [21:0] w, input logic mode_set_command, input logic bad_par);
    mrf_pkg::mrf_ca_s c;
    c.cs_n = 1'b0;
    c.act_n = 1'b1;
    c.ras_n = 1'b0;
    c.cas_n = 1'b0;
    // refresh when not a mode-set
    c.we_n = ~mode_set_command;
    {c.bg, c.ba, c.a17} = w[21:17];
    c.a = w[13:0];
    c.par = ^{c.act_n, c.ras_n, c.cas_n, c.we_n, c.bg, c.ba, c.a17, c.a} ^ bad_par;
    @(posedge i_ck);
    o_ca <= c;
    @(posedge i_ck);
    // released lines must not keep the old value
    c = ~c;
    c.cs_n = 1'b1;
    o_ca <= c;
  endtask : send
endmodule : mrf_ctrl_model

/* File: sim/tb.sv */
// testbench: fifth mode register against the controller model
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_ck = 1'b0;
  logic i_srst = 1'b1;
  logic i_crc_err = 1'b0;
  logic i_mpr_read = 1'b0;
  logic i_power_down = 1'b0;
  logic i_termination_strobe_function_en = 1'b0;
  mrf_pkg::mrf_ca_s ca;
  mrf_pkg::mrf_ca_s o_cmd;
  mrf_pkg::mrf_ca_s last_cmd;
  logic o_cmd_exec;
  logic [21:0] o_mode_reg;
  mrf_pkg::mrf_cfg_s o_cfg;
  logic [21:0] ref_reg = 22'h14_0000;
  logic [21:0] exec_cnt = 22'h0;
  logic [21:0] w;
  logic [21:0] n;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  localparam logic [7:0] OHM [0:7] = '{8'h00, 8'h3c, 8'h78, 8'h28,
                                       8'hf0, 8'h30, 8'h50, 8'h22};
  ////////////////////////////////////////////////////////////////////////
  // clocks; link clock offset so edges never coincide
  always #20 i_clk = ~i_clk;
  initial #7 forever #15 i_ck = ~i_ck;

  mrf_ctrl_model mrf_ctrl_model_i (.i_ck(i_ck), .o_ca(ca));
  mrf_mode_reg #(.ORG_WIDTH(8)) mrf_mode_reg_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_ck(i_ck), .i_ca(ca), .i_crc_err(i_crc_err), .i_mpr_read(i_mpr_read),
    .i_power_down(i_power_down), .i_termination_strobe_function_en(i_termination_strobe_function_en), .o_cmd_exec(o_cmd_exec),
    .o_cmd(o_cmd), .o_mode_reg(o_mode_reg), .o_cfg(o_cfg));

  // executed commands, counted on the link clock; the last one kept for compare
  always @(posedge i_ck)
    if (o_cmd_exec === 1'b1)
    begin
      exec_cnt <= exec_cnt + 22'h1;
      last_cmd <= o_cmd;
    end

  // hang guard
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // expected decode; x8 part so the strobe function is honoured
  function automatic mrf_pkg::mrf_cfg_s exp_cfg(input logic [21:0] r, input logic multipurpose_readout,
                                               input logic pd, input logic ts);
    mrf_pkg::mrf_cfg_s e;
    e = '0;
    e.wr_mask = r[10] & ~ts;
    e.wr_inv = r[11] & ~r[10] & ~ts;
    e.rd_inv = r[12] & ~multipurpose_readout & ~ts;
    e.pin_fn = ts ? mrf_pkg::PIN_TSTROBE : r[10] ? mrf_pkg::PIN_MASK :
               (r[12] | r[11]) ? mrf_pkg::PIN_INV : mrf_pkg::PIN_NONE;
    e.persist = r[9];
    e.park_code = r[8:6];
    e.park_ohms = OHM[r[8:6]];
    e.odt_off_pd = r[5];
    e.nom_term_on = ~(r[5] & pd);
    e.par_err = r[4];
    e.crc_err = r[3];
    e.par_en = (r[2:0] != 3'h0) && (r[2:0] <= 3'h3);
    e.par_lat = e.par_en ? r[2:0] + 3'h3 : 3'h0;
    return e;
  endfunction : exp_cfg

  task automatic chk_word(input logic [21:0] got, input logic [21:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_cfg(input mrf_pkg::mrf_cfg_s got, input mrf_pkg::mrf_cfg_s exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t config %h expected %h", $time, got, exp);
    end
  endtask : chk_cfg

  // long enough for the link path and the config crossing
  task automatic settle();
    repeat (16) @(posedge i_clk);
    #1;
  endtask : settle

  // mode-set to this register with good parity; flags clear on a written 0
  task automatic put(input logic [21:0] v);
    logic [21:0] x;
    x = {1'b0, mrf_pkg::SEL_THIS, 5'h00, v[12:0]};
    mrf_ctrl_model_i.send(x, 1'b1, 1'b0);
    ref_reg = {x[21:5], ref_reg[4:3] & x[4:3], x[2:0]};
    settle();
    chk_word(o_mode_reg, ref_reg);
    chk_cfg(o_cfg, exp_cfg(ref_reg, i_mpr_read, i_power_down, i_termination_strobe_function_en));
  endtask : put

  task automatic bad(input logic mode_set_command);
    mrf_ctrl_model_i.send({1'b0, mrf_pkg::SEL_THIS, 5'h00, 13'h1fff}, mode_set_command, 1'b1);
    settle();
  endtask : bad

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    w = $urandom(32'h9326);
    // held past three link edges so the link side resets too
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    settle();
    chk_word(o_mode_reg, 22'h14_0000);
    chk_cfg(o_cfg, exp_cfg(ref_reg, 1'b0, 1'b0, 1'b0));
    $display("test reset done");
    // every park and latency code, then random words
    for (int k = 0; k < 14; k++)
    begin
      w = $urandom;
      if (k < 8)
        {w[8:6], w[2:0]} = {k[2:0], k[2:0]};
      // never write inversion with mask; no gear-down here
      if (w[10])
        w[11] = 1'b0;
      put(w);
    end
    $display("test codes done");
    // other select codes leave this register alone but still execute
    for (int s = 0; s < 8; s++)
      if (s != 5)
      begin
        n = exec_cnt;
        mrf_ctrl_model_i.send({1'b0, s[2:0], 5'h00, 13'h0aaa}, 1'b1, 1'b0);
        settle();
        chk_word(o_mode_reg, ref_reg);
        chk_word(exec_cnt, n + 22'h1);
        chk_word({3'h0, last_cmd.bg, last_cmd.ba, last_cmd.a17, last_cmd.a},
                 {3'h0, 1'b0, s[2:0], 1'b0, 14'h0aaa});
      end
    $display("test select done");
    // parity refusal, paused check, persistent check, clear
    put(22'h000001);
    n = exec_cnt;
    bad(1'b1);
    ref_reg[4] = 1'b1;
    chk_word(o_mode_reg, ref_reg);
    chk_word(exec_cnt, n);
    bad(1'b0);
    chk_word(exec_cnt, n + 22'h1);
    put(22'h000201);
    bad(1'b0);
    bad(1'b0);
    ref_reg[4] = 1'b1;
    chk_word(exec_cnt, n + 22'h2);
    chk_cfg(o_cfg, exp_cfg(ref_reg, 1'b0, 1'b0, 1'b0));
    put(22'h000010);
    put(22'h000000);
    bad(1'b0);
    chk_word(exec_cnt, n + 22'h5);
    $display("test parity done");
    // crc flag is sticky until written as 0
    @(posedge i_clk);
    i_crc_err <= 1'b1;
    @(posedge i_clk);
    i_crc_err <= 1'b0;
    settle();
    ref_reg[3] = 1'b1;
    chk_word(o_mode_reg, ref_reg);
    put(22'h000008);
    put(22'h000000);
    $display("test crc done");
    // readout, power-down and strobe inputs against both inversions
    put(22'h001820);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge i_clk);
      {i_mpr_read, i_power_down, i_termination_strobe_function_en} <= i[2:0];
      repeat (4) @(posedge i_clk);
      #1;
      chk_cfg(o_cfg, exp_cfg(ref_reg, i[2], i[1], i[0]));
    end
    $display("test inputs done");
    // second reset mid-run
    @(posedge i_clk);
    i_srst <= 1'b1;
    {i_mpr_read, i_power_down, i_termination_strobe_function_en} <= 3'h0;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    ref_reg = 22'h14_0000;
    settle();
    chk_word(o_mode_reg, ref_reg);
    put(22'h000400);
    $display("test rereset done");
    print_verdict();
  end
endmodule : tb
